// file: lec_pkg.sv
// lec_pkg: constants for the link enhancement control register bank
package lec_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [7:0] LEC_OFFSET = 8'hf4;
    localparam logic [31:0] LEC_RESET = 32'h0000_4000;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int LEC_PIPE_OFF_BIT = 15;
    localparam int LEC_DRAFT_BIT = 14;
    localparam int LEC_LEVEL_LSB = 12;
    localparam int LEC_LEVEL_MSB = 13;
    localparam int LEC_RSVD_BIT = 11;
    localparam int LEC_LANE_HI = 1;

    // ----------------------------------------------------------------
    // reset values of the fields
    // ----------------------------------------------------------------
    localparam logic LEC_PIPE_OFF_RST = 1'b0;
    localparam logic LEC_DRAFT_RST = 1'b1;
    localparam logic [1:0] LEC_LEVEL_RST = 2'b00;

    // ----------------------------------------------------------------
    // start level encodings and thresholds in bytes
    // ----------------------------------------------------------------
    localparam logic [1:0] LEC_LEVEL_4K = 2'b00;
    localparam logic [1:0] LEC_LEVEL_1K7 = 2'b01;
    localparam logic [1:0] LEC_LEVEL_1K = 2'b10;
    localparam logic [1:0] LEC_LEVEL_512 = 2'b11;
    localparam int LEC_FILL_MIN_W = 13;
    localparam logic [12:0] LEC_THR_4K = 13'h1000;
    localparam logic [12:0] LEC_THR_1K7 = 13'h06cd;
    localparam logic [12:0] LEC_THR_1K = 13'h0400;
    localparam logic [12:0] LEC_THR_512 = 13'h0200;

endpackage : lec_pkg

// file: lec_start_gate.sv
// lec_start_gate: decides when the async transmit fifo may start a packet
`timescale 1ns/1ps
`default_nettype none
module lec_start_gate
    import lec_pkg::*;
#(
    parameter int FILL_W = 13
) (
    input wire logic [1:0] level,
    input wire logic store_forward,
    input wire logic [FILL_W-1:0] fill,
    input wire logic packet_whole,
    output logic start_ok,
    output logic [FILL_W-1:0] threshold
);

    // a narrower fill count would wrap the 4K threshold to a small number
    if (FILL_W < LEC_FILL_MIN_W) begin : g_fill_too_narrow
        $error("FILL_W must hold a 4K byte fill count");
    end

    // ----------------------------------------------------------------
    // threshold select
    // ----------------------------------------------------------------
    always_comb begin
        case (level)
            LEC_LEVEL_1K7: threshold = FILL_W'(LEC_THR_1K7);
            LEC_LEVEL_1K: threshold = FILL_W'(LEC_THR_1K);
            LEC_LEVEL_512: threshold = FILL_W'(LEC_THR_512);
            default: threshold = FILL_W'(LEC_THR_4K);
        endcase
        if (store_forward) begin
            threshold = FILL_W'(LEC_THR_4K);
        end
    end

    // ----------------------------------------------------------------
    // start decision
    // ----------------------------------------------------------------
    always_comb begin
        if (store_forward || (level == LEC_LEVEL_4K)) begin
            // only a complete packet may leave, so no underrun is possible
            start_ok = packet_whole;
        end else begin
            start_ok = packet_whole || (fill >= threshold);
        end
    end

endmodule : lec_start_gate
`default_nettype wire

// file: lec_link_enhancement.sv
// lec_link_enhancement: link enhancement control register, upper bits, and its effects
//
// Behaviour
// - enhancement bits act only while the phy enhancement gate is set.
// - contents load from software writes or from a serial eeprom image.
// - bits 31 to 16 always read as zero.
// - pipeline-off bit stops out-of-order async transmit pipelining; resets to zero.
// - newer-features bit permits clearing link power status through the clear alias.
// - newer-features bit permits setting bit 9 of receive transfer status.
// - two-bit level selects 4K, 1.7K, 1K or 512 byte start threshold.
// - after an underrun the retried packet uses the 4K store-and-forward threshold.
// - reduced threshold starts at threshold fill or whole packet, whichever first.
// - fifo draining before packet remainder arrives is an underrun.
// - 4K threshold holds data until end-of-packet token is in the fifo.
// - async transmit retries of zero forces store-and-forward.
// - bit 11 always reads as zero.
`timescale 1ns/1ps
`default_nettype none
module lec_link_enhancement
    import lec_pkg::*;
#(
    parameter int FILL_W = 13,
    parameter int RETRY_W = 32
) (
    input wire logic clk_sys,
    input wire logic nrst,
    // configuration space access
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [7:0] cfg_addr,
    input wire logic [3:0] cfg_be,
    input wire logic [31:0] cfg_wdata,
    output logic [31:0] cfg_rdata,
    output logic cfg_rvalid,
    // serial eeprom image load
    input wire logic eeprom_load,
    input wire logic [31:0] eeprom_data,
    // rest of the link
    input wire logic phy_enhancement_gate,
    input wire logic [RETRY_W-1:0] async_transmit_retries,
    input wire logic [FILL_W-1:0] tx_fifo_fill,
    input wire logic tx_fifo_empty,
    input wire logic tx_packet_whole,
    input wire logic tx_active,
    input wire logic tx_packet_done,
    output logic tx_start_ok,
    output logic [FILL_W-1:0] tx_threshold,
    output logic tx_underrun,
    output logic tx_store_forward,
    output logic tx_pipeline_off,
    output logic lps_clear_enable,
    output logic xfer_bit9_enable
);

    // ----------------------------------------------------------------
    // elaboration checks
    // ----------------------------------------------------------------
    if (FILL_W < LEC_FILL_MIN_W) begin : g_fill_too_narrow
        $error("FILL_W must hold a 4K byte fill count");
    end
    if (RETRY_W < 1) begin : g_retry_too_narrow
        $error("RETRY_W must be at least one");
    end
    // the write decode takes every stored field from byte lane one
    if ((LEC_PIPE_OFF_BIT / 8 != LEC_LANE_HI)
        || (LEC_DRAFT_BIT / 8 != LEC_LANE_HI)
        || (LEC_LEVEL_MSB / 8 != LEC_LANE_HI)
        || (LEC_LEVEL_LSB / 8 != LEC_LANE_HI)) begin : g_lane_mismatch
        $error("stored fields must all sit in byte lane one");
    end
    if (LEC_LEVEL_MSB != LEC_LEVEL_LSB + 1) begin : g_level_width
        $error("start level field must be two bits wide");
    end
    if (LEC_RSVD_BIT != LEC_LEVEL_LSB - 1) begin : g_rsvd_place
        $error("reserved bit must sit directly below the start level field");
    end

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic pipeline_off;
        logic draft;
        logic [1:0] level;
        logic fallback;
        logic underrun;
        logic eff_pipeline_off;
        logic eff_lps_clear;
        logic eff_bit9;
        logic [31:0] rdata;
        logic rvalid;
    } lec_state_s;

    lec_state_s st;
    lec_state_s next_st;

    logic underrun_now;
    logic force_saf;
    logic [1:0] eff_level;
    logic [31:0] reg_view;
    logic hit;
    logic sw_write;
    logic sw_read;

    // ----------------------------------------------------------------
    // read view
    // ----------------------------------------------------------------
    always_comb begin
        reg_view = 32'h0000_0000;
        reg_view[LEC_PIPE_OFF_BIT] = st.pipeline_off;
        reg_view[LEC_DRAFT_BIT] = st.draft;
        reg_view[LEC_LEVEL_MSB:LEC_LEVEL_LSB] = st.level;
        reg_view[LEC_RSVD_BIT] = 1'b0;
    end

    assign hit = (cfg_addr == LEC_OFFSET);

    // ----------------------------------------------------------------
    // access decode
    // ----------------------------------------------------------------
    // only lane one holds storage, so writes on the other lanes are dropped quietly
    assign sw_write = cfg_wr && hit && cfg_be[LEC_LANE_HI];
    // other offsets still get cfg_rvalid with zero data, so the host never stalls
    assign sw_read = cfg_rd && hit;

    // ----------------------------------------------------------------
    // transmit threshold control
    // ----------------------------------------------------------------
    // a zero retry budget leaves no second attempt, so the packet must go whole
    assign force_saf = st.fallback
        || (async_transmit_retries == RETRY_W'(0))
        || !phy_enhancement_gate;
    assign eff_level = phy_enhancement_gate ? st.level : LEC_LEVEL_4K;

    // remainder missing once the fifo runs dry mid packet
    assign underrun_now = tx_active && tx_fifo_empty && !tx_packet_whole;

    lec_start_gate #(
        .FILL_W(FILL_W)
    ) u_start_gate (
        .level(eff_level),
        .store_forward(force_saf),
        .fill(tx_fifo_fill),
        .packet_whole(tx_packet_whole),
        .start_ok(tx_start_ok),
        .threshold(tx_threshold)
    );

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        next_st = st;

        // the image carries only the lane one bits that this block stores
        if (eeprom_load) begin
            next_st.pipeline_off = eeprom_data[LEC_PIPE_OFF_BIT];
            next_st.draft = eeprom_data[LEC_DRAFT_BIT];
            next_st.level = eeprom_data[LEC_LEVEL_MSB:LEC_LEVEL_LSB];
        end
        // a software write in the same cycle overrides the eeprom image
        if (sw_write) begin
            next_st.pipeline_off = cfg_wdata[LEC_PIPE_OFF_BIT];
            next_st.draft = cfg_wdata[LEC_DRAFT_BIT];
            next_st.level = cfg_wdata[LEC_LEVEL_MSB:LEC_LEVEL_LSB];
        end

        // fallback ends when the retried packet has gone; a new underrun wins
        if (tx_packet_done) begin
            next_st.fallback = 1'b0;
        end
        if (underrun_now) begin
            next_st.fallback = 1'b1;
        end
        next_st.underrun = underrun_now;

        next_st.eff_pipeline_off = next_st.pipeline_off && phy_enhancement_gate;
        next_st.eff_lps_clear = next_st.draft && phy_enhancement_gate;
        next_st.eff_bit9 = next_st.draft && phy_enhancement_gate;

        next_st.rvalid = cfg_rd;
        next_st.rdata = 32'h0000_0000;
        if (sw_read) begin
            next_st.rdata = reg_view;
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    // effective bits lag the gate by a cycle, but reach the pins free of glitches
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            st.pipeline_off <= LEC_PIPE_OFF_RST;
            st.draft <= LEC_DRAFT_RST;
            st.level <= LEC_LEVEL_RST;
            st.fallback <= 1'b0;
            st.underrun <= 1'b0;
            st.eff_pipeline_off <= 1'b0;
            st.eff_lps_clear <= 1'b0;
            st.eff_bit9 <= 1'b0;
            st.rdata <= 32'h0000_0000;
            st.rvalid <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign cfg_rdata = st.rdata;
    assign cfg_rvalid = st.rvalid;
    assign tx_underrun = st.underrun;
    assign tx_store_forward = force_saf;
    assign tx_pipeline_off = st.eff_pipeline_off;
    assign lps_clear_enable = st.eff_lps_clear;
    assign xfer_bit9_enable = st.eff_bit9;

endmodule : lec_link_enhancement
`default_nettype wire

// file: lec_link_enhancement_monitor.sv
// assertion checker for the link enhancement control register bank
`timescale 1ns/1ps
`default_nettype none
module lec_link_enhancement_monitor
    import lec_pkg::*;
#(
    parameter int FILL_W = 13
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic cfg_rd,
    input wire logic cfg_rvalid,
    input wire logic [31:0] cfg_rdata,
    input wire logic phy_enhancement_gate,
    input wire logic tx_fifo_empty,
    input wire logic tx_packet_whole,
    input wire logic tx_active,
    input wire logic tx_start_ok,
    input wire logic [FILL_W-1:0] tx_threshold,
    input wire logic tx_underrun,
    input wire logic tx_store_forward,
    input wire logic tx_pipeline_off
);
    // ------
    // properties
    // ------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    property p_rv; cfg_rd |=> cfg_rvalid; endproperty
    a_rv: assert property (p_rv) else $error("read unanswered");
    property p_norv; !cfg_rd |=> !cfg_rvalid; endproperty
    a_norv: assert property (p_norv) else $error("stray rvalid");
    property p_rsv; cfg_rvalid |-> cfg_rdata[31:16] == 16'h0000 && !cfg_rdata[11]; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits set");
    property p_gate; !phy_enhancement_gate |=> !tx_pipeline_off; endproperty
    a_gate: assert property (p_gate) else $error("ungated pipeline off");
    property p_hold; tx_store_forward && !tx_packet_whole |-> !tx_start_ok; endproperty
    a_hold: assert property (p_hold) else $error("partial packet started");
    property p_hold4k;
        tx_threshold == LEC_THR_4K && !tx_packet_whole |-> !tx_start_ok;
    endproperty
    a_hold4k: assert property (p_hold4k) else $error("partial packet at 4K level");
    property p_urun; tx_active && tx_fifo_empty && !tx_packet_whole |=> tx_underrun; endproperty
    a_urun: assert property (p_urun) else $error("underrun missed");
    property p_fb; tx_underrun |-> tx_store_forward && tx_threshold == LEC_THR_4K; endproperty
    a_fb: assert property (p_fb) else $error("no fallback");
    property p_early; !tx_store_forward && tx_packet_whole |-> tx_start_ok; endproperty
    a_early: assert property (p_early) else $error("whole packet held");
    c_urun: cover property (tx_underrun);
    c_rd: cover property (cfg_rvalid && cfg_rdata[15]);
    c_cut: cover property (tx_start_ok && !tx_packet_whole);
endmodule : lec_link_enhancement_monitor
bind lec_link_enhancement lec_link_enhancement_monitor #(.FILL_W(FILL_W)) u_mon (
    .clk_sys, .nrst, .cfg_rd, .cfg_rvalid, .cfg_rdata, .phy_enhancement_gate,
    .tx_fifo_empty, .tx_packet_whole, .tx_active, .tx_start_ok, .tx_threshold,
    .tx_underrun, .tx_store_forward, .tx_pipeline_off
);
`default_nettype wire

// file: test_lec_link_enhancement.sv
// self-checking bench for the link enhancement control register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin errors++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module test_lec_link_enhancement
    import lec_pkg::*;
;
    logic clk_sys = 1'b0, nrst = 1'b0, cfg_wr = 1'b0, cfg_rd = 1'b0, eeprom_load = 1'b0;
    logic phy_enhancement_gate = 1'b1, tx_fifo_empty = 1'b0, tx_packet_whole = 1'b0;
    logic tx_active = 1'b0, tx_packet_done = 1'b0;
    logic [7:0] cfg_addr = 8'h00;
    logic [3:0] cfg_be = 4'h0;
    logic [31:0] cfg_wdata = 32'h0000_0000, eeprom_data = 32'h0000_0000, cfg_rdata;
    logic [31:0] async_transmit_retries = 32'h0000_0001;
    logic [12:0] tx_fifo_fill = 13'h0000, tx_threshold;
    logic cfg_rvalid, tx_start_ok, tx_underrun, tx_store_forward, tx_pipeline_off;
    logic lps_clear_enable, xfer_bit9_enable;
    logic [12:0] thr [4] = '{13'h1000, 13'h06cd, 13'h0400, 13'h0200};
    int errors = 0, comparisons = 0;
    lec_link_enhancement DUT (.clk_sys, .nrst, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_be,
        .cfg_wdata, .cfg_rdata, .cfg_rvalid, .eeprom_load, .eeprom_data,
        .phy_enhancement_gate, .async_transmit_retries, .tx_fifo_fill, .tx_fifo_empty,
        .tx_packet_whole, .tx_active, .tx_packet_done, .tx_start_ok, .tx_threshold,
        .tx_underrun, .tx_store_forward, .tx_pipeline_off, .lps_clear_enable,
        .xfer_bit9_enable);
    initial forever #10 clk_sys = ~clk_sys;
    // ------
    // access tasks and the close-out task
    // ------
    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        @(posedge clk_sys);
        cfg_wr <= 1'b1;
        cfg_addr <= a;
        cfg_be <= be;
        cfg_wdata <= d;
        @(posedge clk_sys);
        cfg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_sys);
        cfg_rd <= 1'b1;
        cfg_addr <= a;
        @(posedge clk_sys);
        cfg_rd <= 1'b0;
        #1;
        `CHK(cfg_rvalid, 1'b1)
        `CHK(cfg_rdata, e)
    endtask : rd
    task automatic close_out;
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : close_out
    // a hang costs about ten times the normal run
    initial begin
        #10000;
        errors++;
        close_out();
    end
    initial begin
        repeat (2) @(posedge clk_sys);
        nrst <= 1'b1;
        rd(LEC_OFFSET, LEC_RESET);
        `CHK(xfer_bit9_enable, 1'b1)
        wr(LEC_OFFSET, 4'hf, 32'hffff_ffff);
        rd(LEC_OFFSET, 32'h0000_f000);
        `CHK(tx_pipeline_off, 1'b1)
        @(posedge clk_sys);
        phy_enhancement_gate <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
        `CHK(tx_pipeline_off, 1'b0)
        `CHK(xfer_bit9_enable, 1'b0)
        `CHK(lps_clear_enable, 1'b0)
        `CHK(tx_store_forward, 1'b1)
        `CHK(tx_threshold, LEC_THR_4K)
        @(posedge clk_sys);
        phy_enhancement_gate <= 1'b1;
        wr(LEC_OFFSET, 4'hd, 32'h0000_0000);
        rd(LEC_OFFSET, 32'h0000_f000);
        rd(8'hf8, 32'h0000_0000);
        @(posedge clk_sys);
        eeprom_load <= 1'b1;
        eeprom_data <= 32'hffff_1fff;
        @(posedge clk_sys);
        eeprom_load <= 1'b0;
        rd(LEC_OFFSET, 32'h0000_1000);
        `CHK(lps_clear_enable, 1'b0)
        for (int l = 0; l < 4; l++) begin
            wr(LEC_OFFSET, 4'h2, 32'(l) << 12);
            @(posedge clk_sys);
            tx_fifo_fill <= thr[l] - 13'h0001;
            #1;
            `CHK(tx_threshold, thr[l])
            `CHK(tx_start_ok, 1'b0)
            @(posedge clk_sys);
            tx_fifo_fill <= thr[l];
            #1;
            `CHK(tx_start_ok, l != 0)
            @(posedge clk_sys);
            tx_packet_whole <= 1'b1;
            #1;
            `CHK(tx_start_ok, 1'b1)
            @(posedge clk_sys);
            tx_packet_whole <= 1'b0;
        end
        async_transmit_retries <= 32'h0000_0000;
        #1;
        `CHK(tx_store_forward, 1'b1)
        @(posedge clk_sys);
        async_transmit_retries <= 32'h0000_0001;
        tx_active <= 1'b1;
        tx_fifo_empty <= 1'b1;
        @(posedge clk_sys);
        tx_active <= 1'b0;
        #1;
        `CHK(tx_underrun, 1'b1)
        `CHK(tx_threshold, LEC_THR_4K)
        @(posedge clk_sys);
        tx_packet_done <= 1'b1;
        tx_fifo_fill <= 13'h0300;
        #1;
        `CHK(tx_start_ok, 1'b0)
        @(posedge clk_sys);
        tx_packet_done <= 1'b0;
        #1;
        `CHK(tx_store_forward, 1'b0)
        `CHK(tx_start_ok, 1'b1)
        wr(LEC_OFFSET, 4'h2, 32'h0000_1000);
        #1;
        `CHK(tx_threshold, LEC_THR_1K7)
        `CHK(tx_start_ok, 1'b0)
        close_out();
    end
endmodule : test_lec_link_enhancement
`default_nettype wire
